// [hw/sdc_cfg.svh]
/*
 Constants for the SDRAM command/clock-enable state logic: mode-register
 field codes, timing figures and cycle counts at a 50 MHz sys_clk.
 Assumes it is included by bare name from the device and controller modules.
*/
`ifndef SDC_CFG_SVH
`define SDC_CFG_SVH
`define SDC_CLK_MHZ 50
`define SDC_ROW_CLOSE_NS 20
`define SDC_ROW_CYCLE_NS 70
`define SDC_DATA_AUTOCLOSE_NS 40
`define SDC_MODE_LOAD_CYC 2
`define SDC_BURST_FULL_PAGE 3'h7
`define SDC_BL_LSB 0
`define SDC_BL_MSB 2
`define SDC_BURST_BEATS 4'h4
// least times round up to whole cycles
`define SDC_NS2CYC(ns) (((ns) * `SDC_CLK_MHZ + 999) / 1000)
`endif

// [hw/sdc_pkg.sv]
/*
 Shared types: command codes used by both ends, and the device states.
 Assumes sdc_cfg.svh supplies the numeric constants.
*/
package sdc_pkg;
   typedef enum logic [3:0] {
      SDC_CMD_DESELECT = 4'h0,
      SDC_CMD_NOP = 4'h1,
      SDC_CMD_HALT = 4'h2,
      SDC_CMD_READ = 4'h3,
      SDC_CMD_WRITE = 4'h4,
      SDC_CMD_OPEN = 4'h5,
      SDC_CMD_CLOSE = 4'h6,
      SDC_CMD_REFRESH = 4'h7,
      SDC_CMD_MODE = 4'h8
   } sdc_cmd_t;
   typedef enum logic [3:0] {
      SDC_ST_IDLE = 4'h0,
      SDC_ST_ACTIVE = 4'h1,
      SDC_ST_WRITE_AC = 4'h2,
      SDC_ST_WREC_AC = 4'h3,
      SDC_ST_REFRESH = 4'h4,
      SDC_ST_MODE_WAIT = 4'h5,
      SDC_ST_SELF = 4'h6,
      SDC_ST_SELF_REC = 4'h7,
      SDC_ST_PDOWN = 4'h8
   } sdc_state_t;
endpackage

// [hw/sdc_if.sv]
/*
 SDRAM command pins between controller and device.
 Assumes one shared sys_clk; all pins are sampled on its rising edge.
*/
`timescale 1ns/1ps
interface sdc_if (
   input wire logic sys_clk
);
   logic clk_en;
   logic chip_sel_n;
   logic row_strobe_n;
   logic col_strobe_n;
   logic write_en_n;
   logic [11:0] addr;
   modport ctrl (
      output clk_en,
      output chip_sel_n,
      output row_strobe_n,
      output col_strobe_n,
      output write_en_n,
      output addr
   );
   modport dev (
      input clk_en,
      input chip_sel_n,
      input row_strobe_n,
      input col_strobe_n,
      input write_en_n,
      input addr
   );
endinterface

// [hw/sdc_decode.sv]
/*
 Pin-level command decoder for the device end.
 Assumes pins are already registered values sampled on sys_clk.
*/
`timescale 1ns/1ps
module sdc_decode (
   input wire logic chip_sel_n,
   input wire logic row_strobe_n,
   input wire logic col_strobe_n,
   input wire logic write_en_n,
   output sdc_pkg::sdc_cmd_t cmd
);
   always_comb begin
      if (chip_sel_n) begin
         cmd = sdc_pkg::SDC_CMD_DESELECT;
      end else begin
         case ({row_strobe_n, col_strobe_n, write_en_n})
            3'h7: cmd = sdc_pkg::SDC_CMD_NOP;
            3'h6: cmd = sdc_pkg::SDC_CMD_HALT;
            3'h5: cmd = sdc_pkg::SDC_CMD_READ;
            3'h4: cmd = sdc_pkg::SDC_CMD_WRITE;
            3'h3: cmd = sdc_pkg::SDC_CMD_OPEN;
            3'h2: cmd = sdc_pkg::SDC_CMD_CLOSE;
            3'h1: cmd = sdc_pkg::SDC_CMD_REFRESH;
            default: cmd = sdc_pkg::SDC_CMD_MODE;
         endcase
      end
   end
endmodule // sdc_decode

// [hw/sdc_device.sv]
/*
 Device end: command acceptance and clock-enable state machine of a
 two-bank SDRAM, reduced to the states this logic owns. Bank 0 and
 bank 1 are tracked only as idle/open flags.
 Assumes the controller keeps its side of the protocol; illegal
 commands are flagged, never acted on.
*/
`timescale 1ns/1ps
`include "sdc_cfg.svh"
module sdc_device #(
   parameter int ROW_CLOSE_CYC = `SDC_NS2CYC(`SDC_ROW_CLOSE_NS),
   parameter int ROW_CYCLE_CYC = `SDC_NS2CYC(`SDC_ROW_CYCLE_NS),
   parameter int AUTOCLOSE_CYC = `SDC_NS2CYC(`SDC_DATA_AUTOCLOSE_NS),
   parameter int MODE_LOAD_CYC = `SDC_MODE_LOAD_CYC
) (
   input wire logic sys_clk,
   input wire logic rst,
   sdc_if.dev pins,
   output logic [1:0] bank_open,
   output sdc_pkg::sdc_state_t state,
   output logic [11:0] mode_code,
   output logic clk_suspended,
   output logic illegal_cmd,
   output logic refresh_pulse
);
   typedef struct packed {
      sdc_pkg::sdc_state_t st;
      logic cke_prev;
      logic [11:0] mode;
      logic [1:0] open;
      logic [7:0] cnt;
      logic [3:0] beats;
      logic wbank;
      logic susp;
      logic illegal;
      logic refr;
   } sdc_dev_t;
   sdc_dev_t q, d;
   sdc_pkg::sdc_cmd_t cmd;
   logic nop_like;
   logic cke_now;

   sdc_decode u_dec (
      .chip_sel_n(pins.chip_sel_n),
      .row_strobe_n(pins.row_strobe_n),
      .col_strobe_n(pins.col_strobe_n),
      .write_en_n(pins.write_en_n),
      .cmd(cmd)
   );

   function automatic logic [7:0] cyc8(input int n);
      cyc8 = (n < 1) ? 8'h01 : 8'(n);
   endfunction

   assign cke_now = pins.clk_en;
   assign nop_like = (cmd == sdc_pkg::SDC_CMD_DESELECT) ||
                     (cmd == sdc_pkg::SDC_CMD_NOP) ||
                     (cmd == sdc_pkg::SDC_CMD_HALT);

   always_comb begin
      d = q;
      d.cke_prev = cke_now;
      d.illegal = 1'b0;
      d.refr = 1'b0;
      if (q.cnt != 8'h00) begin
         d.cnt = q.cnt - 8'h01;
      end
      case (q.st)
         sdc_pkg::SDC_ST_IDLE, sdc_pkg::SDC_ST_ACTIVE: begin
            if (q.cke_prev && !cke_now && q.open == 2'h0) begin
               if (cmd == sdc_pkg::SDC_CMD_REFRESH) begin
                  d.st = sdc_pkg::SDC_ST_SELF;
               end else begin
                  d.st = sdc_pkg::SDC_ST_PDOWN;
               end
            end else if (!q.cke_prev && q.open == 2'h0) begin
               d.st = sdc_pkg::SDC_ST_PDOWN;
            end else if (q.cke_prev && !cke_now) begin
               d.susp = 1'b1;
            end else if (!q.cke_prev && cke_now) begin
               d.susp = 1'b0;
            end else if (q.cke_prev && cke_now && !q.susp) begin
               case (cmd)
                  sdc_pkg::SDC_CMD_OPEN: begin
                     d.open[pins.addr[11]] = 1'b1;
                     d.st = sdc_pkg::SDC_ST_ACTIVE;
                  end
                  sdc_pkg::SDC_CMD_CLOSE: begin
                     if (pins.addr[10]) begin
                        d.open = 2'h0;
                     end else begin
                        d.open[pins.addr[11]] = 1'b0;
                     end
                  end
                  sdc_pkg::SDC_CMD_WRITE: begin
                     if (pins.addr[10]) begin
                        d.wbank = pins.addr[11];
                        d.beats = `SDC_BURST_BEATS;
                        d.st = sdc_pkg::SDC_ST_WRITE_AC;
                     end
                  end
                  sdc_pkg::SDC_CMD_REFRESH: begin
                     // flagged with a bank open, never acted on
                     if (q.open != 2'h0) begin
                        d.illegal = 1'b1;
                     end else begin
                        // row address is internal; pins unused
                        d.refr = 1'b1;
                        d.cnt = cyc8(ROW_CLOSE_CYC);
                        d.st = sdc_pkg::SDC_ST_REFRESH;
                     end
                  end
                  sdc_pkg::SDC_CMD_MODE: begin
                     if (q.open != 2'h0) begin
                        d.illegal = 1'b1;
                     end else begin
                        d.mode = pins.addr;
                        d.cnt = cyc8(MODE_LOAD_CYC);
                        d.st = sdc_pkg::SDC_ST_MODE_WAIT;
                     end
                  end
                  sdc_pkg::SDC_CMD_HALT: begin
                     // only meaningful for full-page bursts
                     d.illegal = q.mode[`SDC_BL_MSB:`SDC_BL_LSB] !=
                                 `SDC_BURST_FULL_PAGE;
                  end
                  default: begin
                  end
               endcase
               if (d.open == 2'h0 && d.st == sdc_pkg::SDC_ST_ACTIVE) begin
                  d.st = sdc_pkg::SDC_ST_IDLE;
               end
            end
         end
         sdc_pkg::SDC_ST_WRITE_AC: begin
            if (cmd == sdc_pkg::SDC_CMD_HALT && q.mode[`SDC_BL_MSB:
                `SDC_BL_LSB] == `SDC_BURST_FULL_PAGE) begin
               d.beats = 4'h0;
            end else if (q.beats != 4'h0) begin
               d.beats = q.beats - 4'h1;
            end
            if (d.beats == 4'h0) begin
               d.cnt = cyc8(AUTOCLOSE_CYC);
               d.st = sdc_pkg::SDC_ST_WREC_AC;
            end
         end
         sdc_pkg::SDC_ST_WREC_AC: begin
            d.illegal = !nop_like;
            if (q.cnt <= 8'h01) begin
               d.open[q.wbank] = 1'b0;
               d.st = (d.open == 2'h0) ? sdc_pkg::SDC_ST_IDLE :
                      sdc_pkg::SDC_ST_ACTIVE;
            end
         end
         sdc_pkg::SDC_ST_REFRESH: begin
            d.illegal = !nop_like;
            if (q.cnt <= 8'h01) begin
               d.st = sdc_pkg::SDC_ST_IDLE;
            end
         end
         sdc_pkg::SDC_ST_MODE_WAIT: begin
            d.illegal = !nop_like;
            if (q.cnt <= 8'h01) begin
               d.st = sdc_pkg::SDC_ST_IDLE;
            end
         end
         sdc_pkg::SDC_ST_SELF: begin
            // only clock enable is watched here, plus the command on its rising edge
            if (!q.cke_prev && cke_now) begin
               d.illegal = !(cmd == sdc_pkg::SDC_CMD_DESELECT ||
                             cmd == sdc_pkg::SDC_CMD_NOP);
               d.cnt = cyc8(ROW_CYCLE_CYC);
               d.st = sdc_pkg::SDC_ST_SELF_REC;
            end
         end
         sdc_pkg::SDC_ST_SELF_REC: begin
            if (q.cke_prev) begin
               d.illegal = !(cmd == sdc_pkg::SDC_CMD_DESELECT ||
                             cmd == sdc_pkg::SDC_CMD_NOP);
               if (!cke_now) begin
                  d.st = sdc_pkg::SDC_ST_PDOWN;
               end else if (q.cnt <= 8'h01) begin
                  d.st = sdc_pkg::SDC_ST_IDLE;
               end
            end
         end
         sdc_pkg::SDC_ST_PDOWN: begin
            if (!q.cke_prev && cke_now) begin
               d.st = sdc_pkg::SDC_ST_IDLE;
            end
         end
         default: begin
            d.st = sdc_pkg::SDC_ST_IDLE;
         end
      endcase
      if (d.st == sdc_pkg::SDC_ST_IDLE) begin
         d.susp = 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         // enable idles high: a low reset value fakes a rising edge
         q <= '{st: sdc_pkg::SDC_ST_IDLE, cke_prev: 1'b1, mode: 12'h000,
                open: 2'h0, cnt: 8'h00, beats: 4'h0, wbank: 1'b0,
                susp: 1'b0, illegal: 1'b0, refr: 1'b0};
      end else begin
         q <= d;
      end
   end

   assign bank_open = q.open;
   assign state = q.st;
   assign mode_code = q.mode;
   assign clk_suspended = q.susp;
   assign illegal_cmd = q.illegal;
   assign refresh_pulse = q.refr;
endmodule // sdc_device

// [hw/sdc_ctrl.sv]
/*
 Controller end: issues at most one command per request, keeping the bank
 and timing constraints the device relies on while clock enable stays high.
 Assumes the user holds req until ack.
*/
`timescale 1ns/1ps
`include "sdc_cfg.svh"
module sdc_ctrl #(
   parameter int GAP_CYC = `SDC_NS2CYC(`SDC_ROW_CYCLE_NS)
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic req,
   input sdc_pkg::sdc_cmd_t req_cmd,
   input wire logic [11:0] req_addr,
   input wire logic req_cke,
   output logic ack,
   sdc_if.ctrl pins
);
   typedef struct packed {
      logic [3:0] pins4;
      logic [11:0] addr;
      logic cke;
      logic ack;
      logic [7:0] wait_cnt;
      logic [1:0] open;
   } sdc_ctl_t;
   sdc_ctl_t q, d;

   function automatic logic [3:0] enc(input sdc_pkg::sdc_cmd_t c);
      case (c)
         sdc_pkg::SDC_CMD_DESELECT: enc = 4'hF;
         sdc_pkg::SDC_CMD_HALT: enc = 4'h6;
         sdc_pkg::SDC_CMD_READ: enc = 4'h5;
         sdc_pkg::SDC_CMD_WRITE: enc = 4'h4;
         sdc_pkg::SDC_CMD_OPEN: enc = 4'h3;
         sdc_pkg::SDC_CMD_CLOSE: enc = 4'h2;
         sdc_pkg::SDC_CMD_REFRESH: enc = 4'h1;
         sdc_pkg::SDC_CMD_MODE: enc = 4'h0;
         default: enc = 4'h7;
      endcase
   endfunction

   always_comb begin
      logic ok;
      ok = 1'b1;
      d = q;
      d.ack = 1'b0;
      d.pins4 = 4'h7;
      d.cke = req_cke;
      if (q.wait_cnt != 8'h00) begin
         d.wait_cnt = q.wait_cnt - 8'h01;
      end
      if (req && !q.ack && q.wait_cnt == 8'h00) begin
         case (req_cmd)
            sdc_pkg::SDC_CMD_OPEN: ok = !q.open[req_addr[11]];
            sdc_pkg::SDC_CMD_READ, sdc_pkg::SDC_CMD_WRITE:
               ok = q.open[req_addr[11]];
            sdc_pkg::SDC_CMD_MODE, sdc_pkg::SDC_CMD_REFRESH:
               ok = (q.open == 2'h0);
            default: ok = 1'b1;
         endcase
         d.ack = 1'b1;
         if (ok) begin
            d.pins4 = enc(req_cmd);
            d.addr = req_addr;
            // fixed worst-case gap
            d.wait_cnt = (GAP_CYC < 1) ? 8'h01 : 8'(GAP_CYC);
            if (req_cmd == sdc_pkg::SDC_CMD_OPEN) begin
               d.open[req_addr[11]] = 1'b1;
            end else if (req_cmd == sdc_pkg::SDC_CMD_CLOSE) begin
               if (req_addr[10]) begin
                  d.open = 2'h0;
               end else begin
                  d.open[req_addr[11]] = 1'b0;
               end
            end else if (req_cmd == sdc_pkg::SDC_CMD_WRITE &&
                         req_addr[10]) begin
               d.open[req_addr[11]] = 1'b0;
               // burst plus recovery outlasts the plain gap
               d.wait_cnt = 8'(GAP_CYC) + 8'(`SDC_BURST_BEATS);
            end
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         q <= '{pins4: 4'hF, addr: 12'h000, cke: 1'b1, ack: 1'b0,
                wait_cnt: 8'h00, open: 2'h0};
      end else begin
         q <= d;
      end
   end

   assign pins.chip_sel_n = q.pins4[3];
   assign pins.row_strobe_n = q.pins4[2];
   assign pins.col_strobe_n = q.pins4[1];
   assign pins.write_en_n = q.pins4[0];
   assign pins.addr = q.addr;
   assign pins.clk_en = q.cke;
   assign ack = q.ack;
endmodule // sdc_ctrl

// [verification/sdc_chk.sv]
/*
 Assertions on the command pins and status of the main pair.
 Assumes instantiation beside the interface joining both ends.
*/
`timescale 1ns/1ps
module sdc_chk (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic chip_sel_n,
   input wire logic row_strobe_n,
   input wire logic col_strobe_n,
   input wire logic write_en_n,
   input wire logic [11:0] addr,
   input wire logic [1:0] bank_open,
   input sdc_pkg::sdc_state_t state,
   input wire logic [11:0] mode_code,
   input wire logic clk_suspended,
   input wire logic illegal_cmd,
   input wire logic refresh_pulse
);
   logic low3;
   logic is_ref;
   logic is_mode;
   logic quiet;
   logic idle;
   assign low3 = !chip_sel_n && !row_strobe_n && !col_strobe_n;
   assign is_ref = low3 && write_en_n;
   assign is_mode = low3 && !write_en_n;
   // deselect or nop only
   assign quiet = chip_sel_n || (row_strobe_n && col_strobe_n && write_en_n);
   assign idle = state == sdc_pkg::SDC_ST_IDLE && bank_open == 2'h0;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   mode_capture_a: assert property (
      idle && is_mode && clk_en && $past(clk_en) |=>
      mode_code == $past(addr) && state == sdc_pkg::SDC_ST_MODE_WAIT)
      else $error("mode load not captured");
   refresh_start_a: assert property (
      idle && is_ref && clk_en && $past(clk_en) |=>
      refresh_pulse && bank_open == 2'h0)
      else $error("refresh not accepted");
   refresh_end_a: assert property (
      state == sdc_pkg::SDC_ST_REFRESH |-> ##[1:2]
      state == sdc_pkg::SDC_ST_IDLE)
      else $error("refresh did not end");
   mode_wait_a: assert property (
      state == sdc_pkg::SDC_ST_MODE_WAIT |-> ##[1:3]
      state == sdc_pkg::SDC_ST_IDLE)
      else $error("mode wait did not end");
   self_entry_a: assert property (
      idle && is_ref && $past(clk_en) && !clk_en |=>
      state == sdc_pkg::SDC_ST_SELF)
      else $error("self refresh not entered");
   self_hold_a: assert property (
      state == sdc_pkg::SDC_ST_SELF && !clk_en |=>
      state == sdc_pkg::SDC_ST_SELF && $stable(mode_code))
      else $error("self refresh left early");
   pdown_in_a: assert property (
      idle && quiet && $past(clk_en) && !clk_en |-> ##[1:2]
      state == sdc_pkg::SDC_ST_PDOWN)
      else $error("power-down not entered");
   pdown_out_a: assert property (
      state == sdc_pkg::SDC_ST_PDOWN && clk_en && !$past(clk_en) |=>
      state == sdc_pkg::SDC_ST_IDLE)
      else $error("power-down not left");
   suspend_on_a: assert property (
      state == sdc_pkg::SDC_ST_ACTIVE && $past(clk_en) && !clk_en
      |-> ##[1:2] clk_suspended)
      else $error("clock not suspended");
   suspend_off_a: assert property (
      clk_suspended && clk_en && !$past(clk_en) |-> ##[1:2] !clk_suspended)
      else $error("suspend not ended");
   no_illegal_a: assert property (
      !illegal_cmd)
      else $error("controller sent an illegal command");
   cover property (state == sdc_pkg::SDC_ST_SELF_REC);
   cover property (state == sdc_pkg::SDC_ST_PDOWN);
   cover property (clk_suspended);
   cover property (refresh_pulse);
endmodule // sdc_chk

// [verification/testbench.sv]
/*
 Self-checking bench: controller and device face each other; a second
 device is driven directly with rule-breaking command sequences.
 Assumes sdc_cfg.svh is on the include path.
*/
`timescale 1ns/1ps
module testbench;
   typedef struct packed {
      sdc_pkg::sdc_cmd_t cmd;
      logic [11:0] addr;
      logic [1:0] banks;
      logic [11:0] mode;
      logic [3:0] refs;
   } sdc_row_t;
   localparam logic [4:0] p_nop = 5'h17, p_open = 5'h13, p_read = 5'h15;
   localparam logic [4:0] p_write = 5'h14, p_halt = 5'h16;
   localparam logic [4:0] p_close = 5'h12, p_ref = 5'h11, p_mode = 5'h10;
   logic sys_clk = 1'b0;
   logic rst, req, req_cke, ack, clk_suspended, illegal, illegal2;
   logic refresh_pulse, ill_seen = 1'b0;
   sdc_pkg::sdc_cmd_t req_cmd;
   logic [11:0] req_addr, mode_code, mode_code2;
   logic [1:0] bank_open, bank_open2;
   sdc_pkg::sdc_state_t state, state2;
   int n_mismatch = 0, comparisons = 0, cycles = 0, n_ref = 0, i;
   sdc_row_t rows [10] = '{
      '{sdc_pkg::SDC_CMD_OPEN, 12'h800, 2'h2, 12'h000, 4'h0},
      '{sdc_pkg::SDC_CMD_OPEN, 12'h000, 2'h3, 12'h000, 4'h0},
      '{sdc_pkg::SDC_CMD_OPEN, 12'h000, 2'h3, 12'h000, 4'h0},
      '{sdc_pkg::SDC_CMD_MODE, 12'h027, 2'h3, 12'h000, 4'h0},
      '{sdc_pkg::SDC_CMD_CLOSE, 12'h400, 2'h0, 12'h000, 4'h0},
      '{sdc_pkg::SDC_CMD_READ, 12'h000, 2'h0, 12'h000, 4'h0},
      '{sdc_pkg::SDC_CMD_MODE, 12'h027, 2'h0, 12'h027, 4'h0},
      '{sdc_pkg::SDC_CMD_REFRESH, 12'h555, 2'h0, 12'h027, 4'h1},
      '{sdc_pkg::SDC_CMD_OPEN, 12'h000, 2'h1, 12'h027, 4'h1},
      '{sdc_pkg::SDC_CMD_WRITE, 12'h400, 2'h0, 12'h027, 4'h1}};
   sdc_if pins_if (.sys_clk(sys_clk));
   sdc_if fault_if (.sys_clk(sys_clk));
   sdc_ctrl sdc_ctrl_inst (.sys_clk(sys_clk), .rst(rst), .req(req),
      .req_cmd(req_cmd), .req_addr(req_addr), .req_cke(req_cke),
      .ack(ack), .pins(pins_if));
   sdc_device sdc_device_inst (.sys_clk(sys_clk), .rst(rst),
      .pins(pins_if), .bank_open(bank_open), .state(state),
      .mode_code(mode_code), .clk_suspended(clk_suspended),
      .illegal_cmd(illegal), .refresh_pulse(refresh_pulse));
   sdc_device sdc_device_inst2 (.sys_clk(sys_clk), .rst(rst),
      .pins(fault_if), .bank_open(bank_open2), .state(state2),
      .mode_code(mode_code2), .clk_suspended(), .illegal_cmd(illegal2),
      .refresh_pulse());
   sdc_chk sdc_chk_inst (.sys_clk(sys_clk), .rst(rst),
      .clk_en(pins_if.clk_en), .chip_sel_n(pins_if.chip_sel_n),
      .row_strobe_n(pins_if.row_strobe_n),
      .col_strobe_n(pins_if.col_strobe_n),
      .write_en_n(pins_if.write_en_n), .addr(pins_if.addr),
      .bank_open(bank_open), .state(state), .mode_code(mode_code),
      .clk_suspended(clk_suspended), .illegal_cmd(illegal),
      .refresh_pulse(refresh_pulse));
   initial begin
      forever #10 sys_clk = ~sys_clk;
   end
   task automatic stop_test();
      if (n_mismatch == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic check(input logic [11:0] got, input logic [11:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // the user holds req until ack, then leaves the gap to run out
   task automatic issue(input sdc_pkg::sdc_cmd_t c, input logic [11:0] a,
      input logic ce);
      int n = 0;
      @(posedge sys_clk);
      req <= 1'b1;
      req_cmd <= c;
      req_addr <= a;
      req_cke <= ce;
      do @(posedge sys_clk); while (ack !== 1'b1 && ++n < 20);
      req <= 1'b0;
      // long enough for an auto-close write and its recovery
      repeat (8) @(posedge sys_clk);
   endtask
   task automatic pin(input logic [4:0] v, input logic [11:0] a);
      @(posedge sys_clk);
      {fault_if.clk_en, fault_if.chip_sel_n, fault_if.row_strobe_n,
         fault_if.col_strobe_n, fault_if.write_en_n} <= v;
      fault_if.addr <= a;
   endtask
   task automatic expect_ill(input logic e);
      logic seen = 1'b0;
      pin(p_nop, 12'h000);
      repeat (2) begin
         @(posedge sys_clk);
         if (illegal2 === 1'b1) seen = 1'b1;
      end
      check({11'h000, seen}, {11'h000, e});
   endtask
   always @(posedge sys_clk) begin
      cycles++;
      if (refresh_pulse === 1'b1) n_ref++;
      if (illegal === 1'b1) ill_seen = 1'b1;
      if (cycles == 4000) begin
         n_mismatch++;
         stop_test();
      end
   end
   initial begin
      rst = 1'b1;
      req = 1'b0;
      req_cmd = sdc_pkg::SDC_CMD_NOP;
      req_addr = 12'h000;
      req_cke = 1'b1;
      {fault_if.clk_en, fault_if.chip_sel_n, fault_if.row_strobe_n,
         fault_if.col_strobe_n, fault_if.write_en_n} = p_nop;
      fault_if.addr = 12'h000;
      repeat (5) @(posedge sys_clk);
      rst <= 1'b0;
      check({mode_code2[11:2], bank_open}, 12'h000);
      check(12'(state), 12'(sdc_pkg::SDC_ST_IDLE));
      // no false enable edge may follow reset
      repeat (2) @(posedge sys_clk);
      check(12'(state), 12'(sdc_pkg::SDC_ST_IDLE));
      check(12'(state2), 12'(sdc_pkg::SDC_ST_IDLE));
      foreach (rows[k]) begin
         issue(rows[k].cmd, rows[k].addr, 1'b1);
         check(12'(bank_open), 12'(rows[k].banks));
         check(mode_code, rows[k].mode);
         check(12'(n_ref), 12'(rows[k].refs));
         check(12'(state), 12'(rows[k].banks != 2'h0 ?
            sdc_pkg::SDC_ST_ACTIVE : sdc_pkg::SDC_ST_IDLE));
      end
      check(12'(ill_seen), 12'h000);
      issue(sdc_pkg::SDC_CMD_REFRESH, 12'h000, 1'b0);
      check(12'(state), 12'(sdc_pkg::SDC_ST_SELF));
      req_cke <= 1'b1;
      repeat (3) @(posedge sys_clk);
      check(12'(state), 12'(sdc_pkg::SDC_ST_SELF_REC));
      repeat (6) @(posedge sys_clk);
      check(12'(state), 12'(sdc_pkg::SDC_ST_IDLE));
      req_cke <= 1'b0;
      repeat (4) @(posedge sys_clk);
      check(12'(state), 12'(sdc_pkg::SDC_ST_PDOWN));
      req_cke <= 1'b1;
      repeat (3) @(posedge sys_clk);
      check(12'(state), 12'(sdc_pkg::SDC_ST_IDLE));
      issue(sdc_pkg::SDC_CMD_OPEN, 12'h000, 1'b1);
      req_cke <= 1'b0;
      repeat (4) @(posedge sys_clk);
      check({11'h000, clk_suspended}, 12'h001);
      req_cke <= 1'b1;
      repeat (4) @(posedge sys_clk);
      check({11'h000, clk_suspended}, 12'h000);
      pin(p_mode, 12'h000);
      pin(p_nop, 12'h000);
      pin(p_open, 12'h000);
      repeat (6) pin(p_nop, 12'h000);
      pin(p_halt, 12'h000);
      expect_ill(1'b1);
      pin(p_close, 12'h400);
      repeat (6) pin(p_nop, 12'h000);
      pin(p_mode, 12'h007);
      pin(p_read, 12'h000);
      expect_ill(1'b1);
      check(mode_code2, 12'h007);
      pin(p_open, 12'h000);
      repeat (6) pin(p_nop, 12'h000);
      pin(p_halt, 12'h000);
      expect_ill(1'b0);
      pin(p_write, 12'h400);
      pin(p_nop, 12'h000);
      // negedge look sees the state settled, before the next drive
      for (i = 0; i < 12 && state2 !== sdc_pkg::SDC_ST_WREC_AC; i++)
         @(negedge sys_clk);
      pin(p_open, 12'h000);
      expect_ill(1'b1);
      repeat (6) @(posedge sys_clk);
      check({4'h0, state2, bank_open2, 2'h0}, 12'h000);
      pin(p_ref, 12'hFFF);
      pin(p_open, 12'h000);
      expect_ill(1'b1);
      check(mode_code2, 12'h007);
      repeat (4) @(posedge sys_clk);
      pin(5'h01, 12'h000);
      pin(5'h00, 12'hABC);
      repeat (2) pin(5'h07, 12'h000);
      check(12'(state2), 12'(sdc_pkg::SDC_ST_SELF));
      check(mode_code2, 12'h007);
      repeat (2) pin(p_nop, 12'h000);
      pin(5'h07, 12'h000);
      repeat (3) @(posedge sys_clk);
      check(12'(state2), 12'(sdc_pkg::SDC_ST_PDOWN));
      stop_test();
   end
endmodule // testbench
